// *** common/loop_density_pkg.sv ***
// Purpose: shared constants and types for the loop code, density and latched status block
// Assumes: 10 MHz mclk_in, byte-wide parallel control port
// Notes:   status register order is sr1, sr2, rx_info_reg_one, rx_info_reg_two everywhere
package loop_density_pkg;

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned LI_RECOVER_MS   = 40;
    localparam int unsigned LI_RECOVER_CYC  = LI_RECOVER_MS * (CLK_HZ / 1000);

    // parallel port addresses
    localparam logic [7:0] SR1_ADDR  = 8'h20;
    localparam logic [7:0] SR2_ADDR  = 8'h21;
    localparam logic [7:0] RX_INFO_REG_ONE_ADDR = 8'h22;
    localparam logic [7:0] RX_INFO_REG_TWO_ADDR = 8'h31;
    localparam logic [7:0] IRQ_MASK_ONE_ADDR = 8'h7F;
    localparam logic [7:0] IRQ_MASK_TWO_ADDR = 8'h6F;
    localparam logic [7:0] COMMON_CONTROL_THREE_ADDR = 8'h30;

    localparam int STAT_NUM = 4;
    localparam int SR1_IDX  = 0;
    localparam int SR2_IDX  = 1;
    localparam int RX_INFO_REG_ONE_IDX = 2;
    localparam int RX_INFO_REG_TWO_IDX = 3;
    localparam logic [STAT_NUM-1:0][7:0] STAT_ADDR = {RX_INFO_REG_TWO_ADDR, RX_INFO_REG_ONE_ADDR, SR2_ADDR, SR1_ADDR};

    // common_control_three fields
    localparam int LINE_IF_RESET_BIT = 0;
    localparam int TLU_BIT   = 1;
    localparam int TLD_BIT   = 2;
    localparam int PDE_BIT   = 3;

    // rx_info_reg_two fields
    localparam int TX_DENSITY_VIOLATION_BIT = 0;
    localparam int RX_DENSITY_VIOLATION_BIT = 1;

    localparam logic [7:0] COMMON_CONTROL_THREE_RST = 8'h00;
    localparam logic [7:0] IMR_RST  = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;

    // loop codes: up is 00001, down is 001; the one sits in the last slot
    localparam logic [2:0] LOOP_UP_LEN   = 3'h5;
    localparam logic [2:0] LOOP_DOWN_LEN = 3'h3;

    // density rules
    localparam int         MAX_ZEROS  = 15;
    localparam int         WIN_N_MAX  = 23;
    localparam int         HIST_LEN   = 8 * (WIN_N_MAX + 1);
    localparam int         TX_FIFO_DEPTH = 16;

    typedef struct packed {
        logic frame;   // bit is a framing bit
        logic data;
    } tx_word_s;

endpackage

// *** hdl/stream_fifo.sv ***
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: DEPTH a power of two, one clock
// Notes:   read data leave through an output register, so one extra word can sit there
`timescale 1ns/10ps
module stream_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("stream_fifo: DEPTH must be a power of two >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;

    wire push = in_valid_in & in_ready_out;
    wire load = (count_reg != '0) & (~out_valid_out | out_ready_in);

    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(load);

    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            in_ready_out  <= 1'b0;
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end else begin
            count_reg    <= count_next;
            // registered full flag: ready drops the cycle the last slot fills
            in_ready_out <= count_next < (AW+1)'(DEPTH);
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (load) begin
                rd_ptr_reg    <= rd_ptr_reg + 1'b1;
                out_data_out  <= mem_reg[rd_ptr_reg];
                out_valid_out <= 1'b1;
            end else if (out_ready_in) begin
                out_valid_out <= 1'b0;
            end
        end
    end
endmodule

// *** hdl/loop_density_status_regs.sv ***
// Purpose: loop code insertion, pulse density monitor and enforcer, line interface reset,
//          latched status registers with masked interrupt pins
// Assumes: all inputs synchronous to mclk_in; tx_tick_in is a one-cycle line bit enable
// Notes:   the transmit bits pass a 16-word buffer before code insertion and enforcement
`timescale 1ns/10ps
module loop_density_status_regs #(
    parameter int LI_RECOVER_CYCLES = loop_density_pkg::LI_RECOVER_CYC,
    parameter int FIFO_DEPTH        = loop_density_pkg::TX_FIFO_DEPTH
) (
    input  wire logic                       mclk_in,
    input  wire logic                       rst_b_in,
    input  wire logic [7:0]                 addr_in,
    input  wire logic [7:0]                 wdata_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    output logic      [7:0]                 rdata_out,
    input  wire logic [7:0]                 sr1_event_in,
    input  wire logic [7:0]                 sr2_event_in,
    input  wire logic [7:0]                 rx_info_reg_one_event_in,
    input  wire logic [5:0]                 rx_info_reg_two_event_in,
    input  wire loop_density_pkg::tx_word_s tx_word_in,
    input  wire logic                       tx_valid_in,
    output logic                            tx_ready_out,
    input  wire logic                       tx_tick_in,
    output logic                            tx_bit_out,
    output logic                            tx_frame_out,
    output logic                            tx_bit_valid_out,
    input  wire logic                       rx_bit_in,
    input  wire logic                       rx_valid_in,
    output logic                            irq_pin_one_out,
    output logic                            irq_pin_two_out,
    output logic                            line_if_reset_out
);
    import loop_density_pkg::*;

    localparam int LIW = $clog2(LI_RECOVER_CYCLES + 1);

    if (LI_RECOVER_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_bad
        $error("loop_density_status_regs: recovery count and buffer depth too small");
    end

    // ---------------- control registers ----------------
    logic [7:0]     common_control_three_reg;
    logic [7:0]     irq_mask_one_reg;
    logic [7:0]     irq_mask_two_reg;
    logic [7:0]     latch_reg [STAT_NUM];
    logic [7:0]     view_reg  [STAT_NUM];
    logic [7:0]     event_w   [STAT_NUM];
    logic [STAT_NUM-1:0] stat_hit_w;

    wire hit_common_control_three = addr_in == COMMON_CONTROL_THREE_ADDR;
    wire hit_irq_mask_one = addr_in == IRQ_MASK_ONE_ADDR;
    wire hit_irq_mask_two = addr_in == IRQ_MASK_TWO_ADDR;

    wire tx_loop_up_ctrl    = common_control_three_reg[TLU_BIT];
    wire tx_loop_down_ctrl  = common_control_three_reg[TLD_BIT];
    wire density_enforce_en = common_control_three_reg[PDE_BIT];
    wire line_if_reset      = common_control_three_reg[LINE_IF_RESET_BIT];

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            common_control_three_reg <= COMMON_CONTROL_THREE_RST;
            irq_mask_one_reg         <= IMR_RST;
            irq_mask_two_reg         <= IMR_RST;
        end else if (wr_in) begin
            if (hit_common_control_three) common_control_three_reg <= wdata_in;
            if (hit_irq_mask_one) irq_mask_one_reg <= wdata_in;
            if (hit_irq_mask_two) irq_mask_two_reg <= wdata_in;
        end
    end

    // ---------------- latched status and information registers ----------------
    logic tx_viol_w;
    logic rx_viol_w;

    assign event_w[SR1_IDX]  = sr1_event_in;
    assign event_w[SR2_IDX]  = sr2_event_in;
    assign event_w[RX_INFO_REG_ONE_IDX] = rx_info_reg_one_event_in;
    assign event_w[RX_INFO_REG_TWO_IDX] = {rx_info_reg_two_event_in, rx_viol_w, tx_viol_w};

    for (genvar i = 0; i < STAT_NUM; i++) begin : g_stat
        assign stat_hit_w[i] = addr_in == STAT_ADDR[i];
        wire [7:0] wmask = (wr_in & stat_hit_w[i]) ? wdata_in : 8'h00;
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                latch_reg[i] <= STAT_RST;
                view_reg[i]  <= STAT_RST;
            end else begin
                // event wins over the clear; a persisting alarm relatches at once
                latch_reg[i] <= (latch_reg[i] & ~wmask) | event_w[i];
                if (wr_in & stat_hit_w[i]) begin
                    view_reg[i] <= (view_reg[i] & ~wmask) | (latch_reg[i] & wmask);
                end else if (rd_in & stat_hit_w[i]) begin
                    view_reg[i] <= 8'h00;
                end
            end
        end
    end

    wire [7:0] rd_stat_w = stat_hit_w[SR1_IDX]  ? view_reg[SR1_IDX]  :
                           stat_hit_w[SR2_IDX]  ? view_reg[SR2_IDX]  :
                           stat_hit_w[RX_INFO_REG_ONE_IDX] ? view_reg[RX_INFO_REG_ONE_IDX] :
                           stat_hit_w[RX_INFO_REG_TWO_IDX] ? view_reg[RX_INFO_REG_TWO_IDX] : 8'h00;
    wire [7:0] rd_data_w = hit_common_control_three ? common_control_three_reg :
                           hit_irq_mask_one ? irq_mask_one_reg :
                           hit_irq_mask_two ? irq_mask_two_reg : rd_stat_w;

    // pending covers bits still latched and bits loaded but not yet read
    wire irq_one_next = |((latch_reg[SR1_IDX] | view_reg[SR1_IDX]) & irq_mask_one_reg);
    wire irq_two_next = |((latch_reg[SR2_IDX] | view_reg[SR2_IDX]) & irq_mask_two_reg);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out       <= 8'h00;
            irq_pin_one_out <= 1'b0;
            irq_pin_two_out <= 1'b0;
        end else begin
            if (rd_in) rdata_out <= rd_data_w;
            irq_pin_one_out <= irq_one_next;
            irq_pin_two_out <= irq_two_next;
        end
    end

    // ---------------- line interface reset ----------------
    logic           line_if_reset_prev_reg;
    logic [LIW-1:0] li_cnt_reg;

    wire li_start = line_if_reset & ~line_if_reset_prev_reg;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_if_reset_prev_reg    <= 1'b0;
            li_cnt_reg        <= '0;
            line_if_reset_out <= 1'b0;
        end else begin
            line_if_reset_prev_reg <= line_if_reset;
            if (li_start) begin
                li_cnt_reg        <= LIW'(LI_RECOVER_CYCLES);
                line_if_reset_out <= 1'b1;
            end else if (li_cnt_reg != '0) begin
                li_cnt_reg        <= li_cnt_reg - 1'b1;
                line_if_reset_out <= li_cnt_reg != LIW'(1);
            end
        end
    end

    // ---------------- transmit path ----------------
    tx_word_s fo_word;
    logic     fo_valid;
    logic     tx_bit_next;
    logic [1:0] need_one_w;
    logic [1:0] viol_w;
    logic [1:0] mon_bit_w;
    logic [1:0] mon_valid_w;
    logic [2:0] pcnt_reg;

    stream_fifo #(
        .WIDTH ($bits(tx_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .mclk_in       (mclk_in),
        .rst_b_in      (rst_b_in),
        .in_data_in    (tx_word_in),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (tx_ready_out),
        .out_data_out  (fo_word),
        .out_valid_out (fo_valid),
        .out_ready_in  (tx_tick_in)
    );

    wire       take      = tx_tick_in & fo_valid;
    wire       loop_on   = tx_loop_up_ctrl | tx_loop_down_ctrl;
    // both set is illegal; loop-up wins so the pattern stays well formed
    wire [2:0] plen      = tx_loop_up_ctrl ? LOOP_UP_LEN : LOOP_DOWN_LEN;
    wire       code_bit  = pcnt_reg == (plen - 3'h1);
    wire       payload   = loop_on ? code_bit : fo_word.data;
    wire       force_one = density_enforce_en & ~fo_word.frame & need_one_w[0];
    assign     tx_bit_next = fo_word.frame ? fo_word.data : (payload | force_one);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pcnt_reg         <= 3'h0;
            tx_bit_out       <= 1'b0;
            tx_frame_out     <= 1'b0;
            tx_bit_valid_out <= 1'b0;
        end else begin
            tx_bit_valid_out <= take;
            if (!loop_on) begin
                pcnt_reg <= 3'h0;
            end else if (take & ~fo_word.frame) begin
                pcnt_reg <= code_bit ? 3'h0 : pcnt_reg + 3'h1;
            end
            if (take) begin
                tx_bit_out   <= tx_bit_next;
                tx_frame_out <= fo_word.frame;
            end
        end
    end

    // ---------------- density monitors: 0 transmit, 1 receive ----------------
    assign mon_bit_w   = {rx_bit_in, tx_bit_next};
    assign mon_valid_w = {rx_valid_in, take};
    assign tx_viol_w   = viol_w[0];
    assign rx_viol_w   = viol_w[1];

    for (genvar s = 0; s < 2; s++) begin : g_mon
        logic [HIST_LEN-1:0]      hist_reg;
        logic [4:0]               zrun_reg;
        logic [7:0]               fill_reg;
        logic [WIN_N_MAX:1][5:0]  cnt_reg;
        logic [WIN_N_MAX:1][5:0]  drop_w;
        logic [WIN_N_MAX:1]       short0_w;
        logic [WIN_N_MAX:1]       short_w;
        wire b = mon_bit_w[s];

        for (genvar n = 1; n <= WIN_N_MAX; n++) begin : g_win
            localparam int W = 8 * (n + 1);
            wire filled = fill_reg >= 8'(W - 1);
            assign drop_w[n]   = cnt_reg[n] - {5'h00, hist_reg[W-1]};
            assign short0_w[n] = filled & (drop_w[n] < 6'(n));
            assign short_w[n]  = filled & ((drop_w[n] + {5'h00, b}) < 6'(n));
        end

        wire zeros_full = zrun_reg >= 5'(MAX_ZEROS);
        assign need_one_w[s] = zeros_full | (|short0_w);
        assign viol_w[s]     = mon_valid_w[s] & ((~b & zeros_full) | (|short_w));

        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                hist_reg <= '0;
                zrun_reg <= 5'h00;
                fill_reg <= 8'h00;
                cnt_reg  <= '0;
            end else if (mon_valid_w[s]) begin
                hist_reg <= {hist_reg[HIST_LEN-2:0], b};
                zrun_reg <= b ? 5'h00 : (zrun_reg == 5'h1F ? zrun_reg : zrun_reg + 5'h01);
                if (fill_reg != 8'(HIST_LEN)) fill_reg <= fill_reg + 8'h01;
                for (int k = 1; k <= WIN_N_MAX; k++) begin
                    cnt_reg[k] <= drop_w[k] + {5'h00, b};
                end
            end
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    a_loop_up_one: assert property (take && !fo_word.frame && tx_loop_up_ctrl && pcnt_reg == 3'h4
        |=> tx_bit_out) else $error("loop-up fifth bit not one");
    a_loop_up_zero: assert property (take && !fo_word.frame && tx_loop_up_ctrl && pcnt_reg < 3'h4
        && !density_enforce_en |=> !tx_bit_out) else $error("loop-up leading bit not zero");
    a_loop_down_one: assert property (take && !fo_word.frame && !tx_loop_up_ctrl && tx_loop_down_ctrl
        && pcnt_reg == 3'h2 |=> tx_bit_out) else $error("loop-down third bit not one");
    a_frame_bit_kept: assert property (take && fo_word.frame |=> tx_frame_out && tx_bit_out == $past(fo_word.data))
        else $error("framing bit overwritten");
    a_enforce_zero_run: assert property (take && density_enforce_en && !fo_word.frame
        && g_mon[0].zrun_reg == 5'(MAX_ZEROS) |=> tx_bit_out) else $error("enforcer let 16 zeros pass");
    a_rx_zero_flag: assert property (rx_valid_in && !rx_bit_in && g_mon[1].zrun_reg >= 5'(MAX_ZEROS)
        |=> latch_reg[RX_INFO_REG_TWO_IDX][RX_DENSITY_VIOLATION_BIT]) else $error("receive zero run not flagged");
    a_latch_holds: assert property (latch_reg[SR1_IDX][0] && !(wr_in && stat_hit_w[SR1_IDX] && wdata_in[0])
        |=> latch_reg[SR1_IDX][0]) else $error("latched bit lost without a write");
    a_write_loads: assert property (wr_in && stat_hit_w[SR2_IDX]
        |=> (view_reg[SR2_IDX] & $past(wdata_in)) == ($past(latch_reg[SR2_IDX]) & $past(wdata_in)))
        else $error("masked write did not load the latched value");
    a_read_clears: assert property (rd_in && !wr_in && stat_hit_w[SR1_IDX] |=> view_reg[SR1_IDX] == 8'h00)
        else $error("read did not clear the status copy");
    a_irq_masked: assert property (irq_mask_one_reg == 8'h00 && $past(irq_mask_one_reg) == 8'h00
        |-> !irq_pin_one_out) else $error("interrupt one raised with all bits masked");
    a_irq_released: assert property (!irq_two_next ##1 !irq_two_next |-> !irq_pin_two_out)
        else $error("interrupt two held with nothing pending");
    a_li_reset_start: assert property (li_start |=> line_if_reset_out [*2])
        else $error("line reset not started by rising control bit");
endmodule

// *** bench/cpu_port_model.sv ***
// Purpose: processor on the parallel control port
// Assumes: strobes launched 10 ns after a rising edge, one access at a time
// Notes:   idle address and data show inverted last values, never a stale copy
`timescale 1ns/10ps
module cpu_port_model (
    input  wire logic       mclk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out = 8'h00,
    output logic      [7:0] wdata_out = 8'h00,
    output logic            wr_out = 1'b0,
    output logic            rd_out = 1'b0
);
    import loop_density_pkg::*;

    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in) #10;
        addr_out  = a;
        wdata_out = d;
        wr_out    = wr;
        rd_out    = !wr;
        @(posedge mclk_in) #10;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = ~a;
        wdata_out = ~d;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        // loop down yields to loop up so the illegal pair never reaches the device
        if (a == COMMON_CONTROL_THREE_ADDR && d[TLU_BIT]) d[TLD_BIT] = 1'b0;
        access(1'b1, a, d);
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        access(1'b0, a, 8'h00);
        d = rdata_in;
    endtask

    task automatic poll_status(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
        write_reg(a, m);
        read_reg(a, d);
        write_reg(a, d & m);
    endtask

    // no elastic stores sit behind this port, so their reset toggle is left out
    task automatic power_up();
        for (int i = 0; i < STAT_NUM; i++) write_reg(STAT_ADDR[i], 8'h00);
        write_reg(IRQ_MASK_ONE_ADDR, IMR_RST);
        write_reg(IRQ_MASK_TWO_ADDR, IMR_RST);
        write_reg(COMMON_CONTROL_THREE_ADDR, COMMON_CONTROL_THREE_RST);
    endtask

    task automatic line_reset(input logic [7:0] c);
        write_reg(COMMON_CONTROL_THREE_ADDR, c & 8'hFE);
        write_reg(COMMON_CONTROL_THREE_ADDR, c | 8'h01);
    endtask
endmodule

// *** bench/test_loop_density_status_regs.sv ***
// Purpose: self-checking bench of loop codes, density monitor, transmit buffer and status
// Assumes: inputs change 10 ns after a rising edge; the processor model owns the register port
// Notes:   line reset recovery shortened to 20 cycles to keep the run short
`timescale 1ns/10ps
module test_loop_density_status_regs;
    import loop_density_pkg::*;
    localparam int         REC = 20;
    localparam logic [7:0] CTL [4] = '{COMMON_CONTROL_THREE_ADDR, IRQ_MASK_ONE_ADDR, IRQ_MASK_TWO_ADDR, 8'h55};
    logic        mclk_in = 1'b0, rst_b_in = 1'b0, wr_in, rd_in, tx_ready_out, tx_bit_out, tx_frame_out;
    logic        tx_valid_in = 1'b0, tx_tick_in = 1'b0, rx_bit_in = 1'b0, rx_valid_in = 1'b0;
    logic        tx_bit_valid_out, irq_one, irq_two, li_rst, fr;
    logic [7:0]  addr_in, wdata_in, rdata_out, rd_val, b;
    logic [7:0]  ev [STAT_NUM] = '{default: 8'h00};
    logic [2:0]  got;
    logic [31:0] seed = 32'h8EA5, r;
    tx_word_s    tx_word_in = '0;
    int          fail_count = 0, num_checks = 0, cycles = 0, n, p, run;
    bit          q [$];

    loop_density_status_regs #(.LI_RECOVER_CYCLES(REC), .FIFO_DEPTH(TX_FIFO_DEPTH)) dut_u (
        .mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .sr1_event_in(ev[0]), .sr2_event_in(ev[1]), .rx_info_reg_one_event_in(ev[2]), .rx_info_reg_two_event_in(ev[3][7:2]),
        .tx_word_in, .tx_valid_in, .tx_ready_out, .tx_tick_in, .tx_bit_out, .tx_frame_out,
        .tx_bit_valid_out, .rx_bit_in, .rx_valid_in, .irq_pin_one_out(irq_one),
        .irq_pin_two_out(irq_two), .line_if_reset_out(li_rst));
    cpu_port_model cpu_u (.mclk_in, .rdata_in(rdata_out), .addr_out(addr_in), .wdata_out(wdata_in),
        .wr_out(wr_in), .rd_out(rd_in));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // loop up is 00001, loop down 001, counted over data bits only
    function automatic logic loop_bit(input int m, input int pos);
        return (m == TLU_BIT) ? (pos % 5 == 4) : (pos % 3 == 2);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // one word through an idle buffer: valid, taken, tick two cycles later, sampled after it
    task automatic send(input logic f, input logic d, output logic [2:0] g);
        tx_word_in  = '{f, d};
        tx_valid_in = 1'b1;
        while (tx_ready_out !== 1'b1) @(posedge mclk_in) #10;
        @(posedge mclk_in) #10 tx_valid_in = 1'b0;
        @(posedge mclk_in) #10 tx_tick_in = 1'b1;
        @(posedge mclk_in) #10 tx_tick_in = 1'b0;
        g = {tx_bit_valid_out, tx_frame_out, tx_bit_out};
    endtask

    task automatic feed(input logic v, input int k);
        rx_bit_in = v;
        repeat (k) @(posedge mclk_in) #10;
    endtask

    initial begin
        forever #50 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        #10 rst_b_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            cpu_u.read_reg(i < 4 ? STAT_ADDR[i] : CTL[i-4], rd_val);
            check(rd_val, 8'h00);
        end
        foreach (CTL[i]) begin
            b = 8'(rnd()) & 8'hF0;
            cpu_u.write_reg(CTL[i], b);
            cpu_u.read_reg(CTL[i], rd_val);
            check(rd_val, i == 3 ? 8'h00 : b);
        end
        cpu_u.power_up();
        for (int i = 0; i < STAT_NUM; i++) begin
            for (int j = 0; j < 2; j++) begin
                b = 8'h01 << ((i == RX_INFO_REG_TWO_IDX) ? 2 + rnd() % 6 : rnd() % 8);
                cpu_u.write_reg(IRQ_MASK_ONE_ADDR, j ? b : ~b);
                cpu_u.write_reg(IRQ_MASK_TWO_ADDR, j ? b : ~b);
                cpu_u.poll_status(STAT_ADDR[i], 8'hFF, rd_val);
                ev[i] = b;
                @(posedge mclk_in) #10 ev[i] = 8'h00;
                repeat (2) @(posedge mclk_in) #10;
                check({6'h00, irq_two, irq_one}, {6'h00, j && i == SR2_IDX, j && i == SR1_IDX});
                cpu_u.poll_status(STAT_ADDR[i], ~b, rd_val);
                check(rd_val, 8'h00);
                cpu_u.poll_status(STAT_ADDR[i], b, rd_val);
                check(rd_val, b);
                repeat (2) @(posedge mclk_in) #10;
                check({6'h00, irq_two, irq_one}, 8'h00);
                cpu_u.poll_status(STAT_ADDR[i], b, rd_val);
                check(rd_val, 8'h00);
            end
            ev[i] = b;
            repeat (2) begin
                cpu_u.poll_status(STAT_ADDR[i], b, rd_val);
                check(rd_val, b);
            end
            ev[i] = 8'h00;
            // the alarm has gone but its bit stays latched until a masked write clears it; clearing it keeps later pin checks clean
            cpu_u.poll_status(STAT_ADDR[i], b, rd_val);
            check(rd_val, b);
        end
        cpu_u.line_reset(8'h00);
        n = 0;
        for (int i = 1; i <= 2 * REC; i++) begin
            @(posedge mclk_in) #10;
            if (i == 1 || i == REC + 1) check({7'h00, li_rst}, {7'h00, i == 1});
            n += li_rst;
        end
        check(8'(n), 8'(REC));
        // fill with the line side stalled, then drain back to back
        tx_valid_in = 1'b1;
        for (int k = 0; k < 40 && tx_ready_out === 1'b1; k++) begin
            r = rnd();
            tx_word_in = '{1'b0, r[0]};
            @(posedge mclk_in) #10;
            q.push_back(r[0]);
        end
        tx_valid_in = 1'b0;
        n = q.size();
        check(8'(n), 8'(TX_FIFO_DEPTH + 1));
        tx_tick_in = 1'b1;
        repeat (n + 4) begin
            @(posedge mclk_in) #10;
            if (tx_bit_valid_out === 1'b1) check({7'h00, tx_bit_out}, {7'h00, q.pop_front()});
        end
        tx_tick_in = 1'b0;
        check(8'(q.size()), 8'h00);
        for (int m = TLU_BIT; m <= TLD_BIT; m++) begin
            cpu_u.write_reg(COMMON_CONTROL_THREE_ADDR, 8'h01 << m);
            p = 0;
            for (int k = 0; k < 16; k++) begin
                fr = (k % 7 == 3);
                r = rnd();
                send(fr, r[0], got);
                check({5'h00, got}, {6'h01, fr, fr ? r[0] : loop_bit(m, p)});
                p += !fr;
            end
            cpu_u.write_reg(COMMON_CONTROL_THREE_ADDR, 8'h00);
            r = rnd();
            send(1'b0, r[0], got);
            check({5'h00, got}, {7'h02, r[0]});
        end
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h03, rd_val);
        send(1'b0, 1'b1, got);
        for (int k = 0; k < 16; k++) begin
            send(1'b0, 1'b0, got);
            if (k == 14) begin
                cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h01, rd_val);
                check(rd_val, 8'h00);
            end
        end
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h01, rd_val);
        check(rd_val, 8'h01);
        // the stream here carries no B8ZS coding, so enabling the enforcer is allowed
        cpu_u.write_reg(COMMON_CONTROL_THREE_ADDR, 8'h01 << PDE_BIT);
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h01, rd_val);
        n = 0;
        run = 0;
        repeat (40) begin
            send(1'b0, 1'b0, got);
            run = got[0] ? 0 : run + 1;
            if (run > n) n = run;
        end
        check({7'h00, n <= MAX_ZEROS}, 8'h01);
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h01, rd_val);
        check(rd_val, 8'h00);
        rx_valid_in = 1'b1;
        feed(1'b1, 1);
        feed(1'b0, 15);
        rx_valid_in = 1'b0;
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h02, rd_val);
        check(rd_val, 8'h00);
        rx_valid_in = 1'b1;
        feed(1'b0, 1);
        feed(1'b1, 200);
        rx_valid_in = 1'b0;
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h02, rd_val);
        check(rd_val, 8'h02);
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h02, rd_val);
        check(rd_val, 8'h00);
        // sparse ones never break the zero rule, only the window rule
        rx_valid_in = 1'b1;
        repeat (8) begin
            feed(1'b1, 1);
            feed(1'b0, 11);
        end
        rx_valid_in = 1'b0;
        cpu_u.poll_status(RX_INFO_REG_TWO_ADDR, 8'h02, rd_val);
        check(rd_val, 8'h02);
        conclude();
    end
endmodule
